/* scpc_pkg.sv */
package scpc_pkg;

  // Register addresses on the serial port
  localparam logic [6:0] ADDR_POWER_MODE = 7'h00;
  localparam logic [6:0] ADDR_REG_STATUS = 7'h01;
  localparam logic [6:0] ADDR_OSC_DRIVE = 7'h02;
  localparam logic [6:0] ADDR_TUNING_CAP = 7'h03;
  localparam logic [6:0] ADDR_PIN_CFG1 = 7'h04;
  localparam logic [6:0] ADDR_SYNTH_LOOP = 7'h05;
  localparam logic [6:0] ADDR_CARRIER_BASE = 7'h06;
  localparam logic [6:0] ADDR_VCO_RANGING = 7'h0E;

  // Field positions
  localparam int PM_SOFT_RESET_BIT = 7;
  localparam int VS_LIVE_LOW_BIT = 0;
  localparam int VS_LIVE_HIGH_BIT = 1;
  localparam int VS_STICKY_LOW_BIT = 2;
  localparam int VS_STICKY_HIGH_BIT = 3;
  localparam int LOOP_FILTER_LSB = 0;
  localparam int LOOP_CPI_LSB = 2;
  localparam int LOOP_BAND_BIT = 4;
  localparam int LOOP_SELECT_BIT = 5;
  localparam int RANGE_START_BIT_BIT = 0;
  localparam int RNG_ERROR_BIT = 1;

  // Power mode codes
  localparam logic [3:0] MODE_POWERDOWN = 4'h0;
  localparam logic [3:0] MODE_STANDBY = 4'h5;
  localparam logic [3:0] MODE_TX_SYNTH = 4'hC;
  localparam logic [3:0] MODE_TX_FULL = 4'hD;

  // Reset values
  localparam logic [3:0] RST_POWER_MODE = 4'h0;
  localparam logic [3:0] RST_OSC_GM = 4'h8;
  localparam logic [5:0] RST_TUNING_CAP = 6'h00;
  localparam logic [3:0] RST_DIV_CODE = 4'h0;
  localparam logic [5:0] RST_SYNTH_LOOP = 6'h00;
  localparam logic [7:0] RST_CARRIER_BYTE = 8'h00;
  // Synchroniser reset levels equal the idle pins, so no false brown-out follows reset
  localparam logic [5:0] RST_ASYNC_IN = 6'h19;

  // Reference output divider: code 1 holds the output high, code 12 is ratio 2048
  localparam logic [3:0] DIV_CODE_MAX = 4'hC;
  localparam int DIV_CNT_W = 11;

  // VCO ranging timing
  localparam int CLK_PERIOD_NS = 8;
  localparam int RANGE_SETTLE_NS = 5000;
  localparam int RANGE_SETTLE_CYC = (RANGE_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] VCO_RANGE_LAST = 4'hF;

  typedef enum logic [0:0] {
    SCPC_RNG_IDLE = 1'b0,
    SCPC_RNG_SETTLE = 1'b1
  } scpc_rng_state_t;

endpackage : scpc_pkg

/* synth_clock_power_control.sv */
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// RQ1: All configuration arrives through the serial slave port from an external master.
// RQ2: Any transmit power mode turns the regulator on automatically.
// RQ3: Regulator starts powered down; only the power mode field turns it on.
// RQ4: Status shows live above-threshold bits for both levels plus sticky copies.
// RQ5: Oscillator is off after power-up; enabled only by power mode.
// RQ6: Four-bit oscillator transconductance field sets crystal drive.
// RQ7: Six-bit tuning capacitor field sets crystal load capacitance.
// RQ8: Reference output is reference clock divided by 1 to 2048, four-bit code; code 1 holds the output high instead of dividing by 1.
// RQ9: For ratios above one the reference output has equal high and low time.
// RQ10: Software can switch the reference output off entirely.
// RQ11: Power-on reset comes from inside the chip, no external circuit.
// RQ12: Master toggles the soft reset bit to perform a full reset.
// RQ13: Power-on or soft reset returns all registers to defaults.
// RQ14: Two carrier words, primary and alternate, one hertz per step.
// RQ15: Carrier select set uses the alternate word, clear uses the primary.
// RQ16: Software sets low band select for the lower frequency band.
// RQ17: Writing one to range start begins an automatic VCO range search.
// RQ18: Range start reads one while ranging runs, zero once finished.
// RQ19: Range error reports whether ranging completed correctly.
// RQ20: Software should run ranging after power-up before using the synthesizer.
// RQ21: Two-bit loop filter select chooses among three filter configurations.
// RQ22: Charge pump current field sets synthesizer charge pump current.
// RQ23: Carrier words span four bytes; selection switches whole words at once.
// RQ24: Sticky status bits stay set until software clears them.
// RQ25: Internal reset held while soft reset bit is one, released on zero.
module synth_clock_power_control (
  // Clock and on-chip power-on reset
  input wire logic sys_clk,
  input wire logic resetn,
  // Serial slave port
  input wire logic spiSelN,
  input wire logic spiClk,
  input wire logic spiMosi,
  output logic spiMiso,
  output logic spiMisoOe,
  // Analog status
  input wire logic vregAbove1v3,
  input wire logic vregAbove2v3,
  input wire logic pllLocked,
  // Power and oscillator controls
  output logic regulatorEnable,
  output logic oscEnable,
  output logic [3:0] oscTransconductance,
  output logic [5:0] tuningCapacitorSelect,
  output logic refClockOutput,
  // Synthesizer controls
  output logic [31:0] activeCarrierWord,
  output logic lowBandSelect,
  output logic [1:0] loopFilterSelect,
  output logic [1:0] chargePumpCurrent,
  output logic [3:0] vcoRange,
  output logic rangingActive
);

  // Three-flop input capture, value accepted when stages two and three agree
  logic [5:0] asyncIn;
  logic [5:0] syncA_reg, syncB_reg, syncC_reg, asyncF_reg;
  assign asyncIn = {pllLocked, vregAbove2v3, vregAbove1v3, spiMosi, spiClk, spiSelN};
  genvar gi;
  generate
    for (gi = 0; gi < 6; gi++) begin : g_sync
      always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
          syncA_reg[gi] <= scpc_pkg::RST_ASYNC_IN[gi];
          syncB_reg[gi] <= scpc_pkg::RST_ASYNC_IN[gi];
          syncC_reg[gi] <= scpc_pkg::RST_ASYNC_IN[gi];
          asyncF_reg[gi] <= scpc_pkg::RST_ASYNC_IN[gi];
        end else begin
          syncA_reg[gi] <= asyncIn[gi];
          syncB_reg[gi] <= syncA_reg[gi];
          syncC_reg[gi] <= syncB_reg[gi];
          if (syncB_reg[gi] == syncC_reg[gi]) begin
            asyncF_reg[gi] <= syncC_reg[gi];
          end
        end
      end
    end
  endgenerate

  logic selN, sclk, mosi, live13, live23, lockOk;
  assign {lockOk, live23, live13, mosi, sclk, selN} = asyncF_reg;

  // Serial slave: mode 0, command byte {write, addr[6:0]}, then data bytes with auto-increment
  logic sclkD_reg, firstByte_reg, isWrite_reg;
  logic [2:0] bitCnt_reg;
  logic [6:0] rxShift_reg, addr_reg;
  logic [7:0] txShift_reg, rxByte, rdData;
  logic [6:0] rdAddr;
  logic sclkRise, sclkFall, byteDone;
  logic wrEn_reg;
  logic [6:0] wrAddr_reg;
  logic [7:0] wrData_reg;
  assign sclkRise = sclk & ~sclkD_reg;
  assign sclkFall = ~sclk & sclkD_reg;
  assign rxByte = {rxShift_reg, mosi};
  assign byteDone = sclkRise & ~selN & (bitCnt_reg == 3'h7);
  assign rdAddr = firstByte_reg ? rxByte[6:0] : 7'(addr_reg + 7'h01);

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      sclkD_reg <= 1'b0;
      bitCnt_reg <= 3'h0;
      rxShift_reg <= 7'h00;
      firstByte_reg <= 1'b1;
      isWrite_reg <= 1'b0;
      addr_reg <= 7'h00;
      txShift_reg <= 8'h00;
      spiMiso <= 1'b0;
      spiMisoOe <= 1'b0;
      wrEn_reg <= 1'b0;
      wrAddr_reg <= 7'h00;
      wrData_reg <= 8'h00;
    end else begin
      sclkD_reg <= sclk;
      wrEn_reg <= 1'b0;
      spiMisoOe <= ~selN;
      if (selN) begin
        bitCnt_reg <= 3'h0;
        firstByte_reg <= 1'b1;
        txShift_reg <= 8'h00;
      end else begin
        if (sclkRise) begin
          rxShift_reg <= rxByte[6:0];
          bitCnt_reg <= 3'(bitCnt_reg + 3'h1);
        end
        if (byteDone) begin // RQ1
          firstByte_reg <= 1'b0;
          if (firstByte_reg) begin
            isWrite_reg <= rxByte[7];
            addr_reg <= rxByte[6:0];
          end else begin
            addr_reg <= 7'(addr_reg + 7'h01);
          end
          if (!firstByte_reg && isWrite_reg) begin
            wrEn_reg <= 1'b1;
            wrAddr_reg <= addr_reg;
            wrData_reg <= rxByte;
          end
          txShift_reg <= rdData;
        end else if (sclkFall) begin
          spiMiso <= txShift_reg[7];
          txShift_reg <= {txShift_reg[6:0], 1'b0};
        end
      end
    end
  end

  // Register state
  logic softReset_reg;
  logic [3:0] powerMode_reg;
  logic sticky13_reg, sticky23_reg;
  logic [3:0] divCode_reg;
  logic [5:0] synthLoop_reg;
  logic [7:0] carrierByte_reg [0:7];
  logic rangeError_reg;
  scpc_pkg::scpc_rng_state_t rngState_reg;
  logic [9:0] settleCnt_reg;
  logic rangeStartWr;
  assign rangeStartWr = wrEn_reg && wrAddr_reg == scpc_pkg::ADDR_VCO_RANGING
                        && wrData_reg[scpc_pkg::RANGE_START_BIT_BIT];

  // Power mode and soft reset; the soft reset bit itself survives so it can be cleared
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      softReset_reg <= 1'b0;
      powerMode_reg <= scpc_pkg::RST_POWER_MODE;
    end else if (wrEn_reg && wrAddr_reg == scpc_pkg::ADDR_POWER_MODE) begin
      softReset_reg <= wrData_reg[scpc_pkg::PM_SOFT_RESET_BIT]; // RQ12 RQ25
      powerMode_reg <= wrData_reg[scpc_pkg::PM_SOFT_RESET_BIT] ? scpc_pkg::RST_POWER_MODE : wrData_reg[3:0];
    end else if (softReset_reg) begin
      powerMode_reg <= scpc_pkg::RST_POWER_MODE; // RQ13
    end
  end

  // Regulator on in any non-powerdown mode, which covers all transmit modes
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      regulatorEnable <= 1'b0; // RQ3 RQ11
      oscEnable <= 1'b0; // RQ5
    end else begin
      regulatorEnable <= (powerMode_reg != scpc_pkg::MODE_POWERDOWN); // RQ2 RQ3
      oscEnable <= (powerMode_reg >= scpc_pkg::MODE_STANDBY); // RQ5
    end
  end

  // Sticky brown-out flags: a low level sets, write one clears, set wins
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      sticky13_reg <= 1'b0;
      sticky23_reg <= 1'b0;
    end else if (softReset_reg) begin
      sticky13_reg <= 1'b0;
      sticky23_reg <= 1'b0;
    end else begin
      if (!live13) begin
        sticky13_reg <= 1'b1; // RQ4
      end else if (wrEn_reg && wrAddr_reg == scpc_pkg::ADDR_REG_STATUS
                   && wrData_reg[scpc_pkg::VS_STICKY_LOW_BIT]) begin
        sticky13_reg <= 1'b0; // RQ24
      end
      if (!live23) begin
        sticky23_reg <= 1'b1; // RQ4
      end else if (wrEn_reg && wrAddr_reg == scpc_pkg::ADDR_REG_STATUS
                   && wrData_reg[scpc_pkg::VS_STICKY_HIGH_BIT]) begin
        sticky23_reg <= 1'b0; // RQ24
      end
    end
  end

  // Plain configuration fields
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      oscTransconductance <= scpc_pkg::RST_OSC_GM;
      tuningCapacitorSelect <= scpc_pkg::RST_TUNING_CAP;
      divCode_reg <= scpc_pkg::RST_DIV_CODE;
      synthLoop_reg <= scpc_pkg::RST_SYNTH_LOOP;
    end else if (softReset_reg) begin
      oscTransconductance <= scpc_pkg::RST_OSC_GM; // RQ13
      tuningCapacitorSelect <= scpc_pkg::RST_TUNING_CAP;
      divCode_reg <= scpc_pkg::RST_DIV_CODE;
      synthLoop_reg <= scpc_pkg::RST_SYNTH_LOOP;
    end else if (wrEn_reg) begin
      if (wrAddr_reg == scpc_pkg::ADDR_OSC_DRIVE) oscTransconductance <= wrData_reg[3:0]; // RQ6
      if (wrAddr_reg == scpc_pkg::ADDR_TUNING_CAP) tuningCapacitorSelect <= wrData_reg[5:0]; // RQ7
      if (wrAddr_reg == scpc_pkg::ADDR_PIN_CFG1) divCode_reg <= wrData_reg[3:0]; // RQ8
      if (wrAddr_reg == scpc_pkg::ADDR_SYNTH_LOOP) synthLoop_reg <= wrData_reg[5:0]; // RQ21 RQ22
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      loopFilterSelect <= 2'h0;
      chargePumpCurrent <= 2'h0;
      lowBandSelect <= 1'b0;
    end else begin
      loopFilterSelect <= synthLoop_reg[scpc_pkg::LOOP_FILTER_LSB +: 2]; // RQ21
      chargePumpCurrent <= synthLoop_reg[scpc_pkg::LOOP_CPI_LSB +: 2]; // RQ22
      lowBandSelect <= synthLoop_reg[scpc_pkg::LOOP_BAND_BIT]; // RQ16
    end
  end

  // Carrier bytes, most significant byte at the lower address; primary then alternate
  generate
    for (gi = 0; gi < 8; gi++) begin : g_carrier
      always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
          carrierByte_reg[gi] <= scpc_pkg::RST_CARRIER_BYTE;
        end else if (softReset_reg) begin
          carrierByte_reg[gi] <= scpc_pkg::RST_CARRIER_BYTE;
        end else if (wrEn_reg && wrAddr_reg == 7'(scpc_pkg::ADDR_CARRIER_BASE + gi)) begin
          carrierByte_reg[gi] <= wrData_reg; // RQ14
        end
      end
    end
  endgenerate

  logic [31:0] primaryCarrierWord, alternateCarrierWord;
  assign primaryCarrierWord = {carrierByte_reg[0], carrierByte_reg[1], carrierByte_reg[2], carrierByte_reg[3]};
  assign alternateCarrierWord = {carrierByte_reg[4], carrierByte_reg[5], carrierByte_reg[6], carrierByte_reg[7]};

  // Whole-word switch so a select change never shows a half-written word
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      activeCarrierWord <= 32'h00000000;
    end else begin
      activeCarrierWord <= synthLoop_reg[scpc_pkg::LOOP_SELECT_BIT] ? alternateCarrierWord
                                                                    : primaryCarrierWord; // RQ15 RQ23
    end
  end

  // Reference output divider: ratio 2^(code-1); bit j of a free counter has equal halves
  localparam int DIV_W = scpc_pkg::DIV_CNT_W;
  logic [DIV_W-1:0] divCnt_reg;
  logic [3:0] divCodeSat;
  assign divCodeSat = (divCode_reg > scpc_pkg::DIV_CODE_MAX) ? scpc_pkg::DIV_CODE_MAX : divCode_reg;
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      divCnt_reg <= '0;
      refClockOutput <= 1'b0;
    end else begin
      divCnt_reg <= DIV_W'(divCnt_reg + 1'b1);
      if (divCodeSat == 4'h0) begin
        refClockOutput <= 1'b0; // RQ10
      end else if (divCodeSat == 4'h1) begin
        refClockOutput <= 1'b1; // RQ8
      end else begin
        refClockOutput <= divCnt_reg[divCodeSat - 4'h2]; // RQ8 RQ9
      end
    end
  end

  // VCO auto-ranging: step through ranges, settle, accept the first that locks
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rngState_reg <= scpc_pkg::SCPC_RNG_IDLE;
      settleCnt_reg <= 10'h000;
      vcoRange <= 4'h0;
      rangeError_reg <= 1'b0;
      rangingActive <= 1'b0;
    end else if (softReset_reg) begin
      rngState_reg <= scpc_pkg::SCPC_RNG_IDLE;
      settleCnt_reg <= 10'h000;
      vcoRange <= 4'h0;
      rangeError_reg <= 1'b0;
      rangingActive <= 1'b0;
    end else begin
      unique case (rngState_reg)
        scpc_pkg::SCPC_RNG_IDLE: begin
          if (rangeStartWr) begin // RQ17
            rngState_reg <= scpc_pkg::SCPC_RNG_SETTLE;
            rangingActive <= 1'b1; // RQ18
            vcoRange <= 4'h0;
            settleCnt_reg <= 10'h000;
          end
        end
        scpc_pkg::SCPC_RNG_SETTLE: begin
          if (settleCnt_reg != 10'(scpc_pkg::RANGE_SETTLE_CYC - 1)) begin
            settleCnt_reg <= 10'(settleCnt_reg + 10'h001);
          end else if (lockOk || vcoRange == scpc_pkg::VCO_RANGE_LAST) begin
            rngState_reg <= scpc_pkg::SCPC_RNG_IDLE;
            rangingActive <= 1'b0; // RQ18
            rangeError_reg <= ~lockOk; // RQ19
          end else begin
            vcoRange <= 4'(vcoRange + 4'h1);
            settleCnt_reg <= 10'h000;
          end
        end
      endcase
    end
  end

  // Read multiplexer
  always_comb begin
    rdData = 8'h00;
    if (rdAddr >= scpc_pkg::ADDR_CARRIER_BASE && rdAddr < 7'(scpc_pkg::ADDR_CARRIER_BASE + 7'h08)) begin
      rdData = carrierByte_reg[3'(rdAddr - scpc_pkg::ADDR_CARRIER_BASE)];
    end else begin
      unique case (rdAddr)
        scpc_pkg::ADDR_POWER_MODE: rdData = {softReset_reg, 3'h0, powerMode_reg};
        scpc_pkg::ADDR_REG_STATUS: rdData = {4'h0, sticky23_reg, sticky13_reg, live23, live13}; // RQ4
        scpc_pkg::ADDR_OSC_DRIVE: rdData = {4'h0, oscTransconductance};
        scpc_pkg::ADDR_TUNING_CAP: rdData = {2'h0, tuningCapacitorSelect};
        scpc_pkg::ADDR_PIN_CFG1: rdData = {4'h0, divCode_reg};
        scpc_pkg::ADDR_SYNTH_LOOP: rdData = {2'h0, synthLoop_reg};
        scpc_pkg::ADDR_VCO_RANGING: rdData = {vcoRange, 2'h0, rangeError_reg, rangingActive}; // RQ18 RQ19
        default: rdData = 8'h00;
      endcase
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  a_powerdown_reg_off: assert property (powerMode_reg == scpc_pkg::MODE_POWERDOWN |=> !regulatorEnable) // RQ3
    else $error("regulator on in powerdown mode");
  a_tx_reg_on: assert property ( // RQ2
    (powerMode_reg == scpc_pkg::MODE_TX_SYNTH || powerMode_reg == scpc_pkg::MODE_TX_FULL) |=> regulatorEnable)
    else $error("regulator off in transmit mode");
  a_osc_gated_mode: assert property (powerMode_reg < scpc_pkg::MODE_STANDBY |=> !oscEnable) // RQ5
    else $error("oscillator on without request");
  a_sticky_low_set: assert property (!live13 && !softReset_reg |=> sticky13_reg) // RQ4
    else $error("sticky low flag missed a low level");
  a_sticky_hold: assert property ( // RQ24
    sticky23_reg && !softReset_reg && !(wrEn_reg && wrAddr_reg == scpc_pkg::ADDR_REG_STATUS) |=> sticky23_reg)
    else $error("sticky flag dropped without clear");
  a_carrier_atomic: assert property ( // RQ15
    1'b1 |=> activeCarrierWord == ($past(synthLoop_reg[scpc_pkg::LOOP_SELECT_BIT])
    ? $past(alternateCarrierWord) : $past(primaryCarrierWord)))
    else $error("carrier word does not follow select");
  a_range_start: assert property ( // RQ17
    rangeStartWr && !softReset_reg && rngState_reg == scpc_pkg::SCPC_RNG_IDLE |=> rangingActive ##1 rangingActive)
    else $error("ranging did not start");
  a_range_done: assert property ( // RQ19
    $fell(rangingActive) && !$past(softReset_reg) |-> rangeError_reg == !$past(lockOk))
    else $error("range error does not match lock result");
  a_soft_reset_hold: assert property ( // RQ13
    softReset_reg && !(wrEn_reg && wrAddr_reg == scpc_pkg::ADDR_POWER_MODE)
    |=> powerMode_reg == scpc_pkg::RST_POWER_MODE && !rangingActive)
    else $error("registers not at default under soft reset");
  a_refclk_off: assert property (divCodeSat == 4'h0 |=> !refClockOutput) // RQ10
    else $error("reference output driven while disabled");

endmodule : synth_clock_power_control

`default_nettype wire

/* scpc_spi_master.sv */
`timescale 1ns/1ps
`default_nettype none

module scpc_spi_master (
  // Clock
  input wire logic sys_clk,
  // Serial port
  output logic spiSelN,
  output logic spiClk,
  output logic spiMosi,
  input wire logic spiMiso
);
  localparam int HALF = 8;

  initial begin
    spiSelN = 1'b1;
    spiClk = 1'b0;
    spiMosi = 1'b0;
  end

  // Mode 0: data changes while clock is low, slave data taken just before the rise
  task automatic shift_byte(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      spiMosi <= tx[i];
      repeat (HALF) @(posedge sys_clk);
      rx[i] = spiMiso;
      spiClk <= 1'b1;
      repeat (HALF) @(posedge sys_clk);
      spiClk <= 1'b0;
    end
  endtask : shift_byte

  task automatic frame(input logic [7:0] cmd, input logic [31:0] tx, input int nBytes, output logic [31:0] rx);
    logic [7:0] b;
    @(posedge sys_clk);
    spiSelN <= 1'b0;
    shift_byte(cmd, b);
    rx = 32'h0;
    for (int k = nBytes - 1; k >= 0; k--) begin
      shift_byte(tx[8*k +: 8], b);
      rx[8*k +: 8] = b;
    end
    repeat (HALF) @(posedge sys_clk);
    spiSelN <= 1'b1;
    // Released data line does not keep its last level
    spiMosi <= ~spiMosi;
    repeat (HALF) @(posedge sys_clk);
  endtask : frame

  task automatic write_reg(input logic [6:0] addr, input logic [7:0] data);
    logic [31:0] rx;
    frame({1'b1, addr}, {24'h0, data}, 1, rx);
  endtask : write_reg

  task automatic write_word(input logic [6:0] addr, input logic [31:0] data);
    logic [31:0] rx;
    frame({1'b1, addr}, data, 4, rx);
  endtask : write_word

  task automatic read_reg(input logic [6:0] addr, output logic [7:0] data);
    logic [31:0] rx;
    frame({1'b0, addr}, 32'h0, 1, rx);
    data = rx[7:0];
  endtask : read_reg
endmodule : scpc_spi_master

`default_nettype wire

/* synth_clock_power_control_tb.sv */
`timescale 1ns/1ps
`default_nettype none

module synth_clock_power_control_tb;
  logic sys_clk, resetn, spiSelN, spiClk, spiMosi, spiMiso, spiMisoOe;
  logic vregAbove1v3, vregAbove2v3, pllLocked, regulatorEnable, oscEnable, refClockOutput;
  logic lowBandSelect, rangingActive;
  logic [3:0] oscTransconductance, vcoRange;
  logic [5:0] tuningCapacitorSelect;
  logic [31:0] activeCarrierWord;
  logic [1:0] loopFilterSelect, chargePumpCurrent;
  logic [3:0] modes[4] = '{scpc_pkg::MODE_STANDBY, scpc_pkg::MODE_TX_SYNTH, scpc_pkg::MODE_TX_FULL,
                           scpc_pkg::MODE_POWERDOWN};
  int divCodes[4] = '{2, 3, 12, 15};
  int divHalf[4] = '{1, 2, 1024, 1024};
  int err_total = 0;
  int total_checks = 0;
  int lockAt = -1;
  int g;

  synth_clock_power_control i_synth_clock_power_control (
    .sys_clk(sys_clk), .resetn(resetn), .spiSelN(spiSelN), .spiClk(spiClk), .spiMosi(spiMosi),
    .spiMiso(spiMiso), .spiMisoOe(spiMisoOe), .vregAbove1v3(vregAbove1v3), .vregAbove2v3(vregAbove2v3),
    .pllLocked(pllLocked), .regulatorEnable(regulatorEnable), .oscEnable(oscEnable),
    .oscTransconductance(oscTransconductance), .tuningCapacitorSelect(tuningCapacitorSelect),
    .refClockOutput(refClockOutput), .activeCarrierWord(activeCarrierWord), .lowBandSelect(lowBandSelect),
    .loopFilterSelect(loopFilterSelect), .chargePumpCurrent(chargePumpCurrent), .vcoRange(vcoRange),
    .rangingActive(rangingActive)
  );

  scpc_spi_master i_scpc_spi_master (
    .sys_clk(sys_clk), .spiSelN(spiSelN), .spiClk(spiClk), .spiMosi(spiMosi), .spiMiso(spiMiso)
  );

  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  // Synthesizer locks only on the chosen range
  always @(posedge sys_clk) pllLocked <= (lockAt >= 0) && (vcoRange == lockAt[3:0]);

  task automatic final_report();
    $display("Checks made: %0d, mismatches: %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : final_report

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t ns: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : check

  task automatic wr(input logic [6:0] addr, input logic [7:0] data);
    i_scpc_spi_master.write_reg(addr, data);
  endtask : wr

  task automatic rdc(input logic [6:0] addr, input logic [7:0] exp, input string what);
    logic [7:0] d;
    i_scpc_spi_master.read_reg(addr, d);
    check(d, exp, what);
  endtask : rdc

  // Counts one full high and one full low phase of the reference output
  task automatic measure(input int code, input int half);
    int hi;
    int lo;
    hi = 0;
    lo = 0;
    wr(scpc_pkg::ADDR_PIN_CFG1, 8'(code));
    for (g = 0; g < 5000 && refClockOutput !== 1'b0; g++) @(posedge sys_clk);
    for (g = 0; g < 5000 && refClockOutput !== 1'b1; g++) @(posedge sys_clk);
    while (refClockOutput === 1'b1 && hi < 5000) begin
      hi++;
      @(posedge sys_clk);
    end
    while (refClockOutput === 1'b0 && lo < 5000) begin
      lo++;
      @(posedge sys_clk);
    end
    check(hi, half, "ref high time");
    check(lo, half, "ref low time");
  endtask : measure

  task automatic steady(input logic [7:0] code, input int exp);
    int n;
    n = 0;
    wr(scpc_pkg::ADDR_PIN_CFG1, code);
    repeat (64) begin
      @(posedge sys_clk);
      if (refClockOutput === 1'b1) n++;
    end
    check(n, exp, "ref steady level");
  endtask : steady

  task automatic wait_idle();
    for (g = 0; g < 12000 && rangingActive === 1'b1; g++) @(posedge sys_clk);
    check(rangingActive, 1'b0, "ranging finished in time");
  endtask : wait_idle

  initial begin
    resetn = 1'b0;
    vregAbove1v3 = 1'b1;
    vregAbove2v3 = 1'b1;
    repeat (6) @(posedge sys_clk);
    resetn <= 1'b1;
    repeat (8) @(posedge sys_clk);
    check(regulatorEnable, 1'b0, "regulator at reset");
    check(oscEnable, 1'b0, "oscillator at reset");
    check(oscTransconductance, scpc_pkg::RST_OSC_GM, "gm at reset");
    check(refClockOutput, 1'b0, "ref at reset");
    check(activeCarrierWord, 32'h0, "carrier at reset");
    rdc(scpc_pkg::ADDR_PIN_CFG1, 8'h00, "divider code at reset");
    check(spiMisoOe, 1'b0, "miso released when idle");
    fork
      rdc(7'h20, 8'h00, "unmapped read");
      begin
        repeat (40) @(posedge sys_clk);
        check(spiMisoOe, 1'b1, "miso driven while selected");
      end
    join
    foreach (modes[i]) begin
      wr(scpc_pkg::ADDR_POWER_MODE, {4'h0, modes[i]});
      check(regulatorEnable, modes[i] != 4'h0, "regulator enable");
      check(oscEnable, modes[i] >= 4'h5, "oscillator enable");
    end
    wr(scpc_pkg::ADDR_OSC_DRIVE, 8'h03);
    check(oscTransconductance, 4'h3, "gm field");
    rdc(scpc_pkg::ADDR_OSC_DRIVE, 8'h03, "gm readback");
    wr(scpc_pkg::ADDR_TUNING_CAP, 8'h2A);
    check(tuningCapacitorSelect, 6'h2A, "cap field");
    rdc(scpc_pkg::ADDR_TUNING_CAP, 8'h2A, "cap readback");
    i_scpc_spi_master.write_word(scpc_pkg::ADDR_CARRIER_BASE, 32'h12345678);
    i_scpc_spi_master.write_word(scpc_pkg::ADDR_CARRIER_BASE + 7'h4, 32'h9ABCDEF0);
    check(activeCarrierWord, 32'h12345678, "primary word");
    rdc(scpc_pkg::ADDR_CARRIER_BASE + 7'h3, 8'h78, "primary low byte");
    wr(scpc_pkg::ADDR_SYNTH_LOOP, 8'h21);
    check(activeCarrierWord, 32'h9ABCDEF0, "alternate word");
    check(loopFilterSelect, 2'h1, "filter 1");
    wr(scpc_pkg::ADDR_SYNTH_LOOP, 8'h1E);
    check(loopFilterSelect, 2'h2, "filter 2");
    check(chargePumpCurrent, 2'h3, "charge pump");
    check(lowBandSelect, 1'b1, "low band");
    check(activeCarrierWord, 32'h12345678, "back to primary");
    foreach (divCodes[i]) measure(divCodes[i], divHalf[i]);
    steady(8'h00, 0);
    steady(8'h01, 64);
    rdc(scpc_pkg::ADDR_REG_STATUS, 8'h03, "status quiet");
    vregAbove2v3 <= 1'b0;
    repeat (10) @(posedge sys_clk);
    vregAbove2v3 <= 1'b1;
    repeat (10) @(posedge sys_clk);
    rdc(scpc_pkg::ADDR_REG_STATUS, 8'h0B, "sticky high threshold");
    vregAbove1v3 <= 1'b0;
    rdc(scpc_pkg::ADDR_REG_STATUS, 8'h0E, "live low threshold");
    vregAbove1v3 <= 1'b1;
    repeat (10) @(posedge sys_clk);
    wr(scpc_pkg::ADDR_REG_STATUS, 8'h0C);
    rdc(scpc_pkg::ADDR_REG_STATUS, 8'h03, "sticky cleared");
    lockAt <= 3;
    wr(scpc_pkg::ADDR_VCO_RANGING, 8'h01);
    check(rangingActive, 1'b1, "ranging started");
    rdc(scpc_pkg::ADDR_VCO_RANGING, 8'h01, "ranging busy");
    wait_idle();
    rdc(scpc_pkg::ADDR_VCO_RANGING, 8'h30, "ranging found");
    check(vcoRange, 4'h3, "range found");
    lockAt <= -1;
    wr(scpc_pkg::ADDR_VCO_RANGING, 8'h01);
    wait_idle();
    rdc(scpc_pkg::ADDR_VCO_RANGING, 8'hF2, "ranging failed");
    wr(scpc_pkg::ADDR_POWER_MODE, 8'h85);
    check(oscTransconductance, scpc_pkg::RST_OSC_GM, "gm in soft reset");
    check(tuningCapacitorSelect, 6'h00, "cap in soft reset");
    check(activeCarrierWord, 32'h0, "carrier in soft reset");
    check(oscEnable, 1'b0, "oscillator in soft reset");
    rdc(scpc_pkg::ADDR_POWER_MODE, 8'h80, "soft reset held");
    wr(scpc_pkg::ADDR_POWER_MODE, 8'h00);
    rdc(scpc_pkg::ADDR_TUNING_CAP, 8'h00, "cap after soft reset");
    rdc(scpc_pkg::ADDR_CARRIER_BASE, 8'h00, "carrier byte after soft reset");
    wr(scpc_pkg::ADDR_OSC_DRIVE, 8'h05);
    rdc(scpc_pkg::ADDR_OSC_DRIVE, 8'h05, "write after release");
    final_report();
  end

  initial begin
    repeat (80000) @(posedge sys_clk);
    err_total++;
    $display("[FAIL] %0t ns: watchdog expired", $time);
    final_report();
  end
endmodule : synth_clock_power_control_tb

`default_nettype wire
